// File: tb/dlw_mem_model.sv
// partner model: display memory plus the host agent that rewrites it.
// assumes one walker read per strobe, data wanted the next cycle only.
`timescale 1ns/1ps

module dlw_mem_model
(
  input wire logic clk,
  input wire logic [23:0] addr,
  input wire logic rd,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:255];

  // unused words hold an unknown node type so stray walks stop
  initial
  begin
    rdata = 16'h0000;
    foreach (mem[i])
      mem[i] = 16'h00ff;
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  // answer one cycle after the strobe, else toggle so stale data fails
  always @(posedge clk)
  begin
    if (rd)
      rdata <= mem[addr[7:0]];
    else
      rdata <= ~rdata;
  end

  // ----------------------------------------------------------------
  // host writes
  // ----------------------------------------------------------------
  // one word per clock, so write order is visible to the walker
  task automatic put(input logic [7:0] a, input logic [15:0] v);
  begin
    @(posedge clk);
    mem[a] <= v;
  end
  endtask

  task automatic put_ptr(input logic [7:0] a, input logic [23:0] p);
  begin
    put(a, 16'h0000);
    put(a + 8'h01, p[15:0]);
    put(a, {8'h00, p[23:16]});
  end
  endtask
endmodule

// File: tb/tb_dlw_walker.sv
// testbench for the display-structure walker with a memory partner.
// assumes the register map and node codes of dlw_defines.svh.
`timescale 1ns/1ps
`include "dlw_defines.svh"

module tb_dlw_walker;
  import dlw_pkg::*;
  logic CLOCK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic [23:0] MEM_ADDR;
  logic MEM_RD;
  logic [15:0] MEM_RDATA;
  logic VEC_VALID;
  dlw_vec_t VEC;
  logic BUSY;
  logic WRITE_OK;
  logic sync_on = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  int vec_cnt = 0;
  dlw_vec_t lv;
  logic [15:0] blk[$];

  // 50 ns period
  always #25 CLOCK = ~CLOCK;

  dlw_walker DUT (.CLOCK(CLOCK), .SRST(SRST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
    .MEM_RDATA(MEM_RDATA), .VEC_VALID(VEC_VALID), .VEC(VEC),
    .BUSY(BUSY), .WRITE_OK(WRITE_OK));

  dlw_mem_model mem (.clk(CLOCK), .addr(MEM_ADDR), .rd(MEM_RD),
    .rdata(MEM_RDATA));

  // endpoint is only valid in the pulse cycle, so latch it there
  always @(posedge CLOCK)
  begin
    if (VEC_VALID === 1'b1)
    begin
      lv <= VEC;
      vec_cnt <= vec_cnt + 1;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge CLOCK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  end
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
    input string what);
  begin
    @(posedge CLOCK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, exp, what);
  end
  endtask

  task automatic ld(input logic [7:0] a);
  begin
    foreach (blk[i])
      mem.put(a + 8'(i), blk[i]);
  end
  endtask

  // start one refresh and wait, bounded, for it to end
  task automatic walk();
    int n;
  begin
    n = 0;
    reg_wr(`DLW_REG_CTRL, {30'h0, sync_on, 1'b1});
    repeat (2) @(posedge CLOCK);
    #1;
    while (BUSY === 1'b1 && n < 3000)
    begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    // the last endpoint pulses as busy falls; let the latch catch it
    @(posedge CLOCK);
    #1;
    chk({31'h0, BUSY}, 32'h0, "walk end");
  end
  endtask

  task automatic results();
  begin
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
  begin
    chk({31'h0, WRITE_OK}, 32'h1, "wok rst");
    rchk(`DLW_REG_STATUS, 32'h2, "status rst");
    rchk(`DLW_REG_LEVEL, 32'h0, "level rst");
    rchk(`DLW_REG_COND, 32'h0, "cond rst");
    rchk(`DLW_REG_FRAMES, 32'h0, "frames rst");
    rchk(8'h20, 32'h0, "unmapped");
    reg_wr(`DLW_REG_ROOT, 32'h10);
    rchk(`DLW_REG_ROOT, 32'h10, "root rw");
    $display("t_reset done");
  end
  endtask

  // clear-then-set on cond bits, bit branch, precise vector node
  task automatic t_chg();
  begin
    blk = '{16'h0001, 16'h0020};
    ld(8'h10);
    // change-bits node descends to the branch node at 0x30
    blk = '{`DLW_NODE_CHG, 16'h0001, 16'h00ff, 16'h000f, 16'h0001,
      16'h0030};
    ld(8'h20);
    blk = '{`DLW_NODE_COND, 16'h0100, 16'h0001, 16'h0040, 16'h0001,
      16'h0060};
    ld(8'h30);
    blk = '{`DLW_NODE_DATA, 16'h010e, 16'h0000, 16'h0000, 16'h0001,
      16'h0055, 16'h1234, 16'h5678, 16'h0007, 16'h1111, 16'h2222,
      16'h3333, 16'h0001, 16'h8000, 16'h7fff};
    ld(8'h40);
    reg_wr(`DLW_REG_COND, 32'h00f0);
    walk();
    rchk(`DLW_REG_COND, 32'h000f, "clear then set");
    chk(vec_cnt, 1, "true branch only");
    chk(lv.x, 32'h11114444, "x");
    chk(lv.y, 32'h33330002, "y");
    chk(lv.z, 32'h8000fffe, "z");
    chk(lv.expo, 32'h7, "expo");
    chk({lv.texture, lv.color}, 32'h12345678, "ext fields");
    chk(lv.pick, 32'h55, "pick");
    chk(lv.dot, 32'h1, "dot");
    rchk(`DLW_REG_PICK, 32'h55, "pick reg");
    $display("t_chg done");
  end
  endtask

  // sync hold-off, buffer swap via level, flag bit set skips fields
  task automatic t_sync();
  begin
    sync_on = 1'b1;
    reg_wr(`DLW_REG_CTRL, 32'h2);
    reg_wr(`DLW_REG_WDONE, 32'h1);
    @(posedge CLOCK);
    #1;
    chk(WRITE_OK, 32'h0, "held off");
    // new buffer contents go in before any pointer points at them
    blk = '{`DLW_NODE_DATA, 16'h800e, 16'h0000, 16'h0000, 16'h0001,
      16'h0066, 16'h0003, 16'h0001, 16'h0000, 16'h0002, 16'h0000,
      16'h0003, 16'h0000};
    ld(8'h80);
    mem.put_ptr(8'h32, 24'h010080);
    mem.put(8'h31, 16'h8002);
    blk = '{16'h0000, 16'hffff, 16'h0002};
    ld(8'h21);
    walk();
    chk(WRITE_OK, 32'h1, "released");
    rchk(`DLW_REG_LEVEL, 32'h2, "level set");
    rchk(`DLW_REG_COND, 32'h000f, "cond kept");
    chk(vec_cnt, 2, "level branch");
    chk(lv.expo, 32'h3, "expo no ext");
    chk(lv.x, 32'h00010000, "x no ext");
    chk(lv.z, 32'h00030000, "z no ext");
    chk(lv.dot, 32'h0, "no dot");
    rchk(`DLW_REG_FRAMES, 32'h2, "frames");
    rchk(`DLW_REG_STATUS, 32'ha, "status sync");
    $display("t_sync done");
  end
  endtask

  // nil entry with junk low word, raw block entry, failed bit test
  task automatic t_raw();
  begin
    reg_wr(`DLW_REG_ROOT, 32'h18);
    blk = '{16'h0000, 16'h0040};
    ld(8'h18);
    walk();
    chk(vec_cnt, 2, "nil no draw");
    rchk(`DLW_REG_STATUS, 32'he, "nil flag");
    blk = '{`DLW_NODE_RAW, 16'h0001, 16'h00b0, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
      16'h0040};
    ld(8'ha0);
    mem.put_ptr(8'h18, 24'h0100a0);
    walk();
    chk(vec_cnt, 3, "raw descends");
    chk(lv.x, 32'h11114444, "raw data");
    rchk(`DLW_REG_STATUS, 32'ha, "nil clear");
    // bit 0 of cond is set, so testing it for off takes the other link
    reg_wr(`DLW_REG_ROOT, 32'h10);
    mem.put(8'h31, 16'h0000);
    mem.put_ptr(8'h34, 24'h0100a0);
    walk();
    chk(vec_cnt, 4, "false branch");
    $display("t_raw done");
  end
  endtask

  // a walk is under a hundred cycles; far beyond that means a hang
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    err_total++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge CLOCK);
    SRST <= 1'b0;
    t_reset();
    t_chg();
    t_sync();
    t_raw();
    results();
  end
endmodule

// File: verilog/dlw_defines.svh
// constants for the display-structure walker: register map, node codes,
// word layouts and reset values.
// assumes 16-bit display memory words and 24-bit word addresses.
`ifndef DLW_DEFINES_SVH
`define DLW_DEFINES_SVH

// ----------------------------------------------------------------
// register map (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define DLW_REG_CTRL    8'h00
`define DLW_REG_ROOT    8'h04
`define DLW_REG_LEVEL   8'h08
`define DLW_REG_COND    8'h0c
`define DLW_REG_WDONE   8'h10
`define DLW_REG_STATUS  8'h14
`define DLW_REG_FRAMES  8'h18
`define DLW_REG_PICK    8'h1c

// control and status bit positions
`define DLW_CTRL_START  0
`define DLW_CTRL_SYNC   1
`define DLW_STAT_BUSY   0
`define DLW_STAT_WOK    1
`define DLW_STAT_NIL    2
`define DLW_STAT_SYNC   3

// ----------------------------------------------------------------
// node type codes (first word of every node)
// ----------------------------------------------------------------
`define DLW_NODE_DATA   16'h0002
`define DLW_NODE_CHG    16'h0010
`define DLW_NODE_COND   16'h0011
`define DLW_NODE_RAW    16'h0012

// ----------------------------------------------------------------
// word layouts and read phases
// ----------------------------------------------------------------
`define DLW_SEL_LEVEL   1'b0
`define DLW_SEL_COND    1'b1
`define DLW_AFLAG_BIT   15
`define DLW_DOT_BIT     8
`define DLW_TEST_KIND   15
`define DLW_TEST_POL    8
`define DLW_DTYPE_BD    8'h0e
`define DLW_NIL_HI      16'h0000
`define DLW_MANT_ZERO   1
`define DLW_PH_ISSUE    2'd0
`define DLW_PH_GOT      2'd2

// address steps, vector counts and coordinate index
`define DLW_STEP        24'h000001
`define DLW_SKIP_FALSE  24'h000003
`define DLW_CNT_LAST    16'h0001
`define DLW_CNT_NONE    16'h0000
`define DLW_COORD_Z     2'd2

// reset values
`define DLW_RST_LEVEL   16'h0000
`define DLW_RST_COND    16'h0000
`define DLW_RST_ROOT    32'h00000000

`endif

// File: verilog/dlw_mant_unpack.sv
// rebuilds one 32-bit vector mantissa from its two stored words.
// assumes the low word was stored shifted down one bit with bit 15 zero.
`timescale 1ns/1ps
`include "dlw_defines.svh"

module dlw_mant_unpack
(
  input wire logic [15:0] hi,
  input wire logic [15:0] lo,
  output logic [31:0] mant
);
  import dlw_pkg::*;

  // ----------------------------------------------------------------
  // unpack
  // ----------------------------------------------------------------
  // shifted low word
  // the bit shifted out on store is gone for good; it returns as zero
  always_comb
  begin
    mant = {hi, lo[14:0], 1'b0};
  end

endmodule

// File: verilog/dlw_pkg.sv
// types shared by the display-structure walker and its helpers.
// assumes dlw_defines.svh is compiled alongside.
package dlw_pkg;

  // ----------------------------------------------------------------
  // walker states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00000,
    ST_RPH    = 5'b00001,
    ST_RPL    = 5'b00010,
    ST_NTYPE  = 5'b00011,
    ST_CB_SEL = 5'b00100,
    ST_CB_CLR = 5'b00101,
    ST_CB_SET = 5'b00110,
    ST_CT     = 5'b00111,
    ST_DPH    = 5'b01000,
    ST_DPL    = 5'b01001,
    ST_DMODE  = 5'b01010,
    ST_DNH    = 5'b01011,
    ST_DNL    = 5'b01100,
    ST_DCNT   = 5'b01101,
    ST_DPICK  = 5'b01110,
    ST_DX1    = 5'b01111,
    ST_DX2    = 5'b10000,
    ST_DEXP   = 5'b10001,
    ST_VH     = 5'b10010,
    ST_VL     = 5'b10011
  } dlw_state_t;

  // ----------------------------------------------------------------
  // one decoded vector endpoint
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] z;
    logic [15:0] expo;
    logic [15:0] pick;
    logic [15:0] color;
    logic [15:0] texture;
    logic dot;
  } dlw_vec_t;

  // ----------------------------------------------------------------
  // all walker state
  // ----------------------------------------------------------------
  typedef struct packed {
    dlw_state_t st;
    logic [1:0] ph;
    logic [23:0] addr;
    logic mem_rd;
    logic [15:0] hi;
    logic ind;
    logic sel;
    logic [15:0] clr;
    logic [15:0] level;
    logic [15:0] cond;
    logic aflag;
    logic [7:0] dtype;
    logic [31:0] nxt;
    logic [15:0] cnt;
    logic [1:0] ci;
    logic [31:0] cx;
    logic [31:0] cy;
    logic vec_valid;
    dlw_vec_t vec;
    logic [31:0] root;
    logic sync;
    logic pend;
    logic busy;
    logic nil_seen;
    logic [15:0] frames;
    logic [31:0] rdata;
  } dlw_regs_t;

endpackage

// File: verilog/dlw_walker.sv
// display-structure walker: traverses display memory once per refresh,
// applies change-bits nodes, branches, raw blocks and decodes
// extended-precision block-normalized vector nodes.
// assumes a read-only memory port with data one cycle after the strobe.
`timescale 1ns/1ps
`include "dlw_defines.svh"

module dlw_walker
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic [23:0] MEM_ADDR,
  output logic MEM_RD,
  input wire logic [15:0] MEM_RDATA,
  output logic VEC_VALID,
  output dlw_pkg::dlw_vec_t VEC,
  output logic BUSY,
  output logic WRITE_OK
);
  import dlw_pkg::*;

  dlw_regs_t s_reg;
  dlw_regs_t s_next;
  logic got;
  logic [31:0] mant;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // read only
  // the memory port cannot write, so nothing linked is ever deleted
  assign MEM_ADDR = s_reg.addr;
  assign MEM_RD = s_reg.mem_rd;
  assign REG_RDATA = s_reg.rdata;
  assign VEC_VALID = s_reg.vec_valid;
  assign VEC = s_reg.vec;
  assign BUSY = s_reg.busy;
  assign WRITE_OK = !(s_reg.sync && s_reg.pend);
  // memory word is on MEM_RDATA in the third phase of each read
  assign got = (s_reg.ph == `DLW_PH_GOT);

  dlw_mant_unpack u_mant
  (
    .hi(s_reg.hi),
    .lo(MEM_RDATA),
    .mant(mant)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // every non-idle state is one three-phase word read
  always_comb
  begin
    logic fin;
    logic go_next;
    logic ok;
    logic [15:0] w;
    logic [15:0] tgt;
    fin = 1'b0;
    go_next = 1'b0;
    ok = 1'b0;
    w = MEM_RDATA;
    tgt = 16'h0000;
    s_next = s_reg;
    s_next.mem_rd = 1'b0;
    s_next.vec_valid = 1'b0;
    s_next.rdata = 32'h00000000;
    if (s_reg.st != ST_IDLE && !got)
    begin
      s_next.ph = s_reg.ph + 2'd1;
      s_next.mem_rd = (s_reg.ph == `DLW_PH_ISSUE);
    end
    else if (s_reg.st != ST_IDLE)
    begin
      s_next.ph = `DLW_PH_ISSUE;
      s_next.addr = s_reg.addr + `DLW_STEP;
      case (s_reg.st)
        // a half-written pointer is seen as nil
        ST_RPH:
        begin
          s_next.hi = w;
          if (w == `DLW_NIL_HI)
            fin = 1'b1;
          else
            s_next.st = ST_RPL;
        end
        ST_RPL:
        begin
          s_next.addr = {s_reg.hi[7:0], w};
          s_next.st = ST_NTYPE;
        end
        ST_NTYPE:
        begin
          s_next.ind = 1'b0;
          case (w)
            `DLW_NODE_CHG: s_next.st = ST_CB_SEL;
            `DLW_NODE_COND: s_next.st = ST_CT;
            `DLW_NODE_DATA: s_next.st = ST_DMODE;
            `DLW_NODE_RAW:
            begin
              s_next.ind = 1'b1;
              s_next.st = ST_DPH;
            end
            default: fin = 1'b1;
          endcase
        end
        ST_CB_SEL:
        begin
          s_next.sel = w[0];
          s_next.st = ST_CB_CLR;
        end
        ST_CB_CLR:
        begin
          s_next.clr = w;
          s_next.st = ST_CB_SET;
        end
        ST_CB_SET:
        begin
          tgt = (s_reg.sel == `DLW_SEL_COND) ? s_reg.cond : s_reg.level;
          tgt = (tgt & ~s_reg.clr) | w;
          if (s_reg.sel == `DLW_SEL_COND)
            s_next.cond = tgt;
          else
            s_next.level = tgt;
          s_next.st = ST_DPH;
        end
        ST_CT:
        begin
          if (w[`DLW_TEST_KIND])
            ok = (s_reg.level[7:0] == w[7:0]);
          else
            ok = (s_reg.cond[w[3:0]] == w[`DLW_TEST_POL]);
          // failing test skips the taken pointer to the other one
          s_next.addr = ok ? s_reg.addr + `DLW_STEP
                           : s_reg.addr + `DLW_SKIP_FALSE;
          s_next.st = ST_DPH;
        end
        ST_DPH:
        begin
          s_next.hi = w;
          if (w == `DLW_NIL_HI)
            fin = 1'b1;
          else
            s_next.st = ST_DPL;
        end
        ST_DPL:
        begin
          s_next.addr = {s_reg.hi[7:0], w};
          s_next.st = s_reg.ind ? ST_RPH : ST_NTYPE;
        end
        ST_DMODE:
        begin
          s_next.aflag = w[`DLW_AFLAG_BIT];
          s_next.vec.dot = w[`DLW_DOT_BIT];
          s_next.dtype = w[7:0];
          s_next.st = ST_DNH;
        end
        ST_DNH:
        begin
          s_next.nxt[31:16] = w;
          s_next.st = ST_DNL;
        end
        ST_DNL:
        begin
          s_next.nxt[15:0] = w;
          s_next.st = ST_DCNT;
        end
        ST_DCNT:
        begin
          s_next.cnt = w;
          s_next.st = ST_DPICK;
        end
        ST_DPICK:
        begin
          s_next.vec.pick = w;
          if (!s_reg.aflag)
            s_next.st = ST_DX1;
          else if (s_reg.dtype == `DLW_DTYPE_BD)
            s_next.st = ST_DEXP;
          else
            go_next = 1'b1;
        end
        ST_DX1:
        begin
          s_next.vec.texture = w;
          s_next.st = ST_DX2;
        end
        ST_DX2:
        begin
          s_next.vec.color = w;
          if (s_reg.dtype == `DLW_DTYPE_BD)
            s_next.st = ST_DEXP;
          else
            go_next = 1'b1;
        end
        ST_DEXP:
        begin
          s_next.vec.expo = w;
          s_next.ci = 2'd0;
          if (s_reg.cnt == `DLW_CNT_NONE)
            go_next = 1'b1;
          else
            s_next.st = ST_VH;
        end
        ST_VH:
        begin
          s_next.hi = w;
          s_next.st = ST_VL;
        end
        ST_VL:
        begin
          s_next.st = ST_VH;
          s_next.ci = s_reg.ci + 2'd1;
          if (s_reg.ci == 2'd0)
            s_next.cx = mant;
          else if (s_reg.ci == 2'd1)
            s_next.cy = mant;
          else
          begin
            s_next.vec.x = s_reg.cx;
            s_next.vec.y = s_reg.cy;
            s_next.vec.z = mant;
            s_next.vec_valid = 1'b1;
            s_next.ci = 2'd0;
            s_next.cnt = s_reg.cnt - `DLW_CNT_LAST;
            if (s_reg.cnt == `DLW_CNT_LAST)
              go_next = 1'b1;
          end
        end
        default: fin = 1'b1;
      endcase
    end
    if (go_next)
    begin
      if (s_reg.nxt[31:16] == `DLW_NIL_HI)
        fin = 1'b1;
      else
      begin
        s_next.addr = {s_reg.nxt[23:16], s_reg.nxt[15:0]};
        s_next.st = ST_NTYPE;
      end
    end
    // end of refresh releases a pending synchronised write
    if (fin)
    begin
      s_next.st = ST_IDLE;
      s_next.busy = 1'b0;
      s_next.nil_seen = (s_reg.st == ST_RPH);
      s_next.frames = s_reg.frames + 16'h0001;
      s_next.pend = 1'b0;
    end
    // register writes; a write-done in the finishing cycle stays pending
    if (REG_WR)
    begin
      case (REG_ADDR)
        `DLW_REG_CTRL:
        begin
          s_next.sync = REG_WDATA[`DLW_CTRL_SYNC];
          // each refresh re-reads the entry pointer
          if (REG_WDATA[`DLW_CTRL_START] && s_reg.st == ST_IDLE)
          begin
            s_next.busy = 1'b1;
            s_next.addr = s_reg.root[23:0];
            s_next.ph = `DLW_PH_ISSUE;
            s_next.st = ST_RPH;
          end
        end
        `DLW_REG_ROOT: s_next.root = REG_WDATA;
        `DLW_REG_LEVEL: s_next.level = REG_WDATA[15:0];
        `DLW_REG_COND: s_next.cond = REG_WDATA[15:0];
        `DLW_REG_WDONE: s_next.pend = s_reg.sync;
        default: ;
      endcase
    end
    // register reads; unmapped offsets return zero
    if (REG_RD)
    begin
      case (REG_ADDR)
        `DLW_REG_CTRL: s_next.rdata[`DLW_CTRL_SYNC] = s_reg.sync;
        `DLW_REG_ROOT: s_next.rdata = s_reg.root;
        `DLW_REG_LEVEL: s_next.rdata[15:0] = s_reg.level;
        `DLW_REG_COND: s_next.rdata[15:0] = s_reg.cond;
        `DLW_REG_STATUS:
        begin
          s_next.rdata[`DLW_STAT_BUSY] = s_reg.busy;
          s_next.rdata[`DLW_STAT_WOK] = WRITE_OK;
          s_next.rdata[`DLW_STAT_NIL] = s_reg.nil_seen;
          s_next.rdata[`DLW_STAT_SYNC] = s_reg.sync;
        end
        `DLW_REG_FRAMES: s_next.rdata[15:0] = s_reg.frames;
        `DLW_REG_PICK: s_next.rdata[15:0] = s_reg.vec.pick;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.level <= `DLW_RST_LEVEL;
      s_reg.cond <= `DLW_RST_COND;
      s_reg.root <= `DLW_RST_ROOT;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  sequence q_cb_set;
    s_reg.st == ST_CB_SET && got && !REG_WR;
  endsequence

  property p_clear_then_set;
    q_cb_set and (s_reg.sel == `DLW_SEL_LEVEL) |=>
      ((s_reg.level & $past(s_reg.clr) & ~$past(MEM_RDATA)) == 16'h0000)
      && ((s_reg.level & $past(MEM_RDATA)) == $past(MEM_RDATA));
  endproperty
  a_clear_then_set: assert property (p_clear_then_set)
    else $error("clear mask not applied before set mask");

  property p_sel_cond;
    q_cb_set and (s_reg.sel == `DLW_SEL_COND) |=>
      s_reg.level == $past(s_reg.level);
  endproperty
  a_sel_cond: assert property (p_sel_cond)
    else $error("conditional-bit update touched detail level");

  property p_branch_skip;
    (s_reg.st == ST_CT && got && !REG_WR && !MEM_RDATA[`DLW_TEST_KIND]
      && s_reg.cond[MEM_RDATA[3:0]] != MEM_RDATA[`DLW_TEST_POL]) |=>
      s_reg.addr == $past(s_reg.addr) + `DLW_SKIP_FALSE;
  endproperty
  a_branch_skip: assert property (p_branch_skip)
    else $error("failed bit test did not take other descendant");

  property p_nil_ptr;
    (s_reg.st == ST_RPH && got && MEM_RDATA == `DLW_NIL_HI && !REG_WR)
      |=> s_reg.st == ST_IDLE ##1 !MEM_RD;
  endproperty
  a_nil_ptr: assert property (p_nil_ptr)
    else $error("nil pointer was followed");

  property p_hi_first;
    (s_reg.st == ST_RPL && $past(s_reg.st) != ST_RPL) |->
      $past(s_reg.st) == ST_RPH;
  endproperty
  a_hi_first: assert property (p_hi_first)
    else $error("pointer low word read before high word");

  property p_raw_indirect;
    (s_reg.st == ST_DPL && got && s_reg.ind && !REG_WR) |=>
      s_reg.st == ST_RPH ##1 MEM_RD;
  endproperty
  a_raw_indirect: assert property (p_raw_indirect)
    else $error("raw block did not read entry pointer");

  property p_ext_skip;
    (s_reg.st == ST_DPICK && got && s_reg.aflag) |=> s_reg.st != ST_DX1;
  endproperty
  a_ext_skip: assert property (p_ext_skip)
    else $error("extended fields read with flag set");

  property p_vec_type;
    VEC_VALID |-> s_reg.dtype == `DLW_DTYPE_BD && $past(s_reg.st) == ST_VL;
  endproperty
  a_vec_type: assert property (p_vec_type)
    else $error("vector emitted for wrong data type");

  property p_sync_hold;
    ($past(!WRITE_OK) && $past(s_reg.sync) && s_reg.sync
      && s_reg.frames == $past(s_reg.frames)) |-> !WRITE_OK;
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("write allowed before a refresh completed");

  property p_chain_end;
    (s_reg.st == ST_VL && got && s_reg.ci == `DLW_COORD_Z
      && s_reg.cnt == `DLW_CNT_LAST && s_reg.nxt[31:16] == `DLW_NIL_HI
      && !REG_WR) |=> s_reg.st == ST_IDLE && VEC_VALID;
  endproperty
  a_chain_end: assert property (p_chain_end)
    else $error("zero next-node link did not end the walk");

endmodule
